// ===== core/bmd_regs.vh
`ifndef BMD_REGS_VH
`define BMD_REGS_VH
// core register offsets within every bank
`define BMD_OFF_INDIRECT_DATA 7'h00
`define BMD_OFF_PC_LOW 7'h02
`define BMD_OFF_STATUS 7'h03
`define BMD_OFF_POINTER 7'h04
`define BMD_OFF_PC_UPPER 7'h0A
`define BMD_OFF_INT_CTRL 7'h0B
// status field positions
`define BMD_STATUS_BANK_LOW 5
`define BMD_STATUS_BANK_HIGH 6
`define BMD_STATUS_IND_BANK 7
// vectors and reset values
`define BMD_RESET_VECTOR 13'h0000
`define BMD_INT_VECTOR 13'h0004
`define BMD_STATUS_RESET 8'h18
`define BMD_PC_UPPER_RESET 5'h00
`define BMD_INT_CTRL_RESET 8'h00
// general ram window within a bank
`define BMD_RAM_FIRST 7'h20
`define BMD_RAM_LAST 7'h7F
`define BMD_SHARED_FIRST 7'h70
`define BMD_SMALL_RAM1_END 7'h40
// program size variants
`define BMD_PROG_LAST_SMALL 13'h07FF
`define BMD_PROG_LAST_LARGE 13'h0FFF
`define BMD_ENDUR_FIRST_SMALL 13'h0780
`define BMD_ENDUR_FIRST_LARGE 13'h0F80
`define BMD_STACK_DEPTH 8
`endif

// ===== core/bmd_ret_stack.v
`timescale 1ns/1ps
`include "bmd_regs.vh"
// circular return-address stack; overflow wraps and overwrites oldest
module bmd_ret_stack #(
  parameter DEPTH = `BMD_STACK_DEPTH,
  parameter PTRW = 3
) (
  input wire clk,
  input wire reset,
  input wire push,
  input wire pop,
  input wire [12:0] push_addr,
  output wire [12:0] top_addr
);
  reg [12:0] mem_ff [0:DEPTH-1];
  reg [PTRW-1:0] ptr_ff;
  integer i;
  wire [PTRW-1:0] ptr_dec = ptr_ff - {{(PTRW-1){1'b0}}, 1'b1};

  assign top_addr = mem_ff[ptr_dec];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_ff <= {PTRW{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= 13'h0000;
      end
    end else if (push) begin
      mem_ff[ptr_ff] <= push_addr;
      ptr_ff <= ptr_ff + {{(PTRW-1){1'b0}}, 1'b1};
    end else if (pop) begin
      ptr_ff <= ptr_dec;
    end
  end
endmodule

// ===== core/bmd_memory_map.v
`timescale 1ns/1ps
`include "bmd_regs.vh"
module bmd_memory_map #(
  parameter LARGE = 1
) (
  input wire SYS_CLK,
  input wire RESET,
  input wire FETCH_ADV,
  input wire JUMP,
  input wire CALL,
  input wire RETURN,
  input wire INT_TAKE,
  input wire [10:0] JUMP_ADDR,
  input wire DATA_RD,
  input wire DATA_WR,
  input wire INDIRECT,
  input wire [6:0] DATA_ADDR,
  input wire [7:0] WR_DATA,
  output reg [12:0] PROG_ADDR,
  output reg PROG_ENDURANCE,
  output reg [7:0] RD_DATA,
  output reg [8:0] DATA_FULL_ADDR,
  output reg PERIPH_SEL,
  output reg [1:0] BANK_SEL
);
  localparam RAM_BYTES = LARGE ? 256 : 128;
  localparam [12:0] PROG_MASK = LARGE ? `BMD_PROG_LAST_LARGE : `BMD_PROG_LAST_SMALL;
  localparam [12:0] ENDUR_FIRST = LARGE ? `BMD_ENDUR_FIRST_LARGE : `BMD_ENDUR_FIRST_SMALL;
  localparam [7:0] BANK_SPAN = {1'b0, `BMD_SHARED_FIRST} - {1'b0, `BMD_RAM_FIRST};
  localparam [7:0] SHARED_BASE = LARGE ? 8'hF0 : 8'h70;

  reg [12:0] pc_ff;
  reg [12:0] nxt_pc;
  reg [7:0] status_ff;
  reg [7:0] pointer_ff;
  reg [4:0] pc_upper_ff;
  reg [7:0] int_ctrl_ff;
  reg [7:0] ram_ff [0:RAM_BYTES-1];
  reg [7:0] rd_value;
  wire [12:0] stack_top;
  wire [8:0] eff_addr;
  wire [6:0] eff_off;
  wire core_hit;
  wire ram_hit;
  wire [7:0] ram_index;
  wire stack_push;
  wire stack_pop;
  wire pc_low_wr;
  wire ram_wr;
  wire [12:0] ret_addr;

  ////////////////////////////////////////////////////////////////////
  // decode helpers

  // maps a 9-bit data address to a ram index; the shared window sits at the top of the array
  function [7:0] ram_idx;
    input [8:0] a;
    reg [7:0] base;
    begin
      case (a[8:7])
        2'b01: base = BANK_SPAN;
        2'b10: base = BANK_SPAN + BANK_SPAN;
        default: base = 8'h00;
      endcase
      if (a[6:0] >= `BMD_SHARED_FIRST)
        ram_idx = SHARED_BASE + {4'h0, a[3:0]};
      else
        ram_idx = {1'b0, a[6:0]} - {1'b0, `BMD_RAM_FIRST} + base;
    end
  endfunction

  // true when the address hits implemented general ram
  function ram_ok;
    input [8:0] a;
    begin
      if (a[6:0] < `BMD_RAM_FIRST)
        ram_ok = 1'b0;
      else if (a[6:0] >= `BMD_SHARED_FIRST)
        ram_ok = 1'b1;
      else if (LARGE)
        ram_ok = (a[8:7] != 2'b11);
      else
        ram_ok = (a[8:7] == 2'b00) || (a[8:7] == 2'b01 && a[6:0] < `BMD_SMALL_RAM1_END);
    end
  endfunction

  function is_core;
    input [6:0] off;
    begin
      is_core = (off == `BMD_OFF_INDIRECT_DATA) || (off == `BMD_OFF_PC_LOW) || (off == `BMD_OFF_STATUS) ||
        (off == `BMD_OFF_POINTER) || (off == `BMD_OFF_PC_UPPER) || (off == `BMD_OFF_INT_CTRL);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // data address formation

  // indirect reads the pointer with the indirect bank bit above it; direct uses the bank bits
  assign eff_addr = INDIRECT ? {status_ff[`BMD_STATUS_IND_BANK], pointer_ff}
    : {status_ff[`BMD_STATUS_BANK_HIGH], status_ff[`BMD_STATUS_BANK_LOW], DATA_ADDR};
  assign eff_off = eff_addr[6:0];
  assign core_hit = is_core(eff_off);
  assign ram_hit = ram_ok(eff_addr);
  assign ram_index = ram_idx(eff_addr);
  assign ram_wr = DATA_WR & ~core_hit & ram_hit;
  // a pc low write reaches the pc through the pointer too
  assign pc_low_wr = DATA_WR & core_hit & (eff_off == `BMD_OFF_PC_LOW);

  always @* begin
    rd_value = 8'h00;
    if (core_hit) begin
      case (eff_off)
        `BMD_OFF_PC_LOW: rd_value = pc_ff[7:0];
        `BMD_OFF_STATUS: rd_value = status_ff;
        `BMD_OFF_POINTER: rd_value = pointer_ff;
        `BMD_OFF_PC_UPPER: rd_value = {3'b000, pc_upper_ff};
        `BMD_OFF_INT_CTRL: rd_value = int_ctrl_ff;
        default: rd_value = 8'h00;
      endcase
    end else if (ram_hit) begin
      rd_value = ram_ff[ram_index];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // program counter

  always @* begin
    nxt_pc = pc_ff;
    if (INT_TAKE)
      nxt_pc = `BMD_INT_VECTOR;
    else if (RETURN)
      nxt_pc = stack_top;
    else if (JUMP || CALL)
      nxt_pc = {pc_upper_ff[4:3], JUMP_ADDR};
    else if (pc_low_wr)
      nxt_pc = {pc_upper_ff, WR_DATA};
    else if (FETCH_ADV)
      nxt_pc = pc_ff + 13'h0001;
  end

  // a call loses to a return in the same cycle, so the stack grows only for an interrupt or for a call that the pc follows
  assign stack_push = INT_TAKE | (CALL & ~RETURN);
  assign stack_pop = RETURN & ~INT_TAKE;
  assign ret_addr = pc_ff + 13'h0001;

  bmd_ret_stack #(
    .DEPTH(`BMD_STACK_DEPTH),
    .PTRW(3)
  ) u_stack (
    .clk(SYS_CLK),
    .reset(RESET),
    .push(stack_push),
    .pop(stack_pop),
    .push_addr(ret_addr),
    .top_addr(stack_top)
  );

  ////////////////////////////////////////////////////////////////////
  // state registers

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      pc_ff <= `BMD_RESET_VECTOR;
      status_ff <= `BMD_STATUS_RESET;
      pointer_ff <= 8'h00;
      pc_upper_ff <= `BMD_PC_UPPER_RESET;
      int_ctrl_ff <= `BMD_INT_CTRL_RESET;
      PROG_ADDR <= `BMD_RESET_VECTOR;
      PROG_ENDURANCE <= 1'b0;
      RD_DATA <= 8'h00;
      DATA_FULL_ADDR <= 9'h000;
      PERIPH_SEL <= 1'b0;
      BANK_SEL <= 2'b00;
    end else begin
      pc_ff <= nxt_pc;
      PROG_ADDR <= nxt_pc & PROG_MASK;
      PROG_ENDURANCE <= ((nxt_pc & PROG_MASK) >= ENDUR_FIRST);
      RD_DATA <= DATA_RD ? rd_value : 8'h00;
      DATA_FULL_ADDR <= eff_addr;
      PERIPH_SEL <= (DATA_RD | DATA_WR) & ~core_hit & ~ram_hit & (eff_off < `BMD_RAM_FIRST);
      if (DATA_WR && core_hit) begin
        case (eff_off)
          `BMD_OFF_STATUS: begin
            status_ff <= WR_DATA;
            // the bank output moves with the status write, in step with the address decode
            BANK_SEL <= {WR_DATA[`BMD_STATUS_BANK_HIGH], WR_DATA[`BMD_STATUS_BANK_LOW]};
          end
          `BMD_OFF_POINTER: pointer_ff <= WR_DATA;
          `BMD_OFF_PC_UPPER: pc_upper_ff <= WR_DATA[4:0];
          `BMD_OFF_INT_CTRL: int_ctrl_ff <= WR_DATA;
          default: pointer_ff <= pointer_ff;
        endcase
      end
    end
  end

  // general ram has no reset, like static ram
  always @(posedge SYS_CLK) begin
    if (ram_wr)
      ram_ff[ram_index] <= WR_DATA;
  end
endmodule

// ===== dv/bmd_core_model.sv
`timescale 1ns/1ps
module bmd_core_model (
  input wire SYS_CLK,
  output reg FETCH_ADV = 1'h0,
  output reg JUMP = 1'h0,
  output reg CALL = 1'h0,
  output reg RETURN = 1'h0,
  output reg INT_TAKE = 1'h0,
  output reg DATA_RD = 1'h0,
  output reg DATA_WR = 1'h0,
  output reg INDIRECT = 1'h0,
  output reg [10:0] JUMP_ADDR = 11'h000,
  output reg [6:0] DATA_ADDR = 7'h00,
  output reg [7:0] WR_DATA = 8'h00
);
  // one request per call, raised after a falling edge and held over one rising edge
  task go(input [6:0] s, input [10:0] a, input [7:0] d, input i);
    @(negedge SYS_CLK);
    {FETCH_ADV, JUMP, CALL, RETURN, INT_TAKE, DATA_RD, DATA_WR} = s;
    {INDIRECT, JUMP_ADDR, DATA_ADDR, WR_DATA} = {i, a, a[6:0], d};
    @(negedge SYS_CLK);
    {FETCH_ADV, JUMP, CALL, RETURN, INT_TAKE, DATA_RD, DATA_WR} = 7'h00;
    // released address and data lines show the inverse, never a stale copy; INDIRECT keeps its value
    {JUMP_ADDR, DATA_ADDR, WR_DATA} = ~{JUMP_ADDR, DATA_ADDR, WR_DATA};
  endtask
endmodule

// ===== dv/bmd_memory_map_monitor.sv
`timescale 1ns/1ps
module bmd_memory_map_monitor #(
  parameter LARGE = 1
) (
  input wire SYS_CLK,
  input wire RESET,
  input wire FETCH_ADV,
  input wire JUMP,
  input wire CALL,
  input wire RETURN,
  input wire INT_TAKE,
  input wire [10:0] JUMP_ADDR,
  input wire DATA_RD,
  input wire DATA_WR,
  input wire INDIRECT,
  input wire [6:0] DATA_ADDR,
  input wire [7:0] WR_DATA,
  input wire [12:0] PROG_ADDR,
  input wire PROG_ENDURANCE,
  input wire [7:0] RD_DATA,
  input wire [8:0] DATA_FULL_ADDR,
  input wire PERIPH_SEL,
  input wire [1:0] BANK_SEL
);
  localparam [12:0] MSK = LARGE ? 13'h0FFF : 13'h07FF;
  localparam [12:0] EDGE = LARGE ? 13'h0F80 : 13'h0780;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire pc_busy = JUMP | CALL | RETURN | INT_TAKE | DATA_WR;
  sequence only_fetch; FETCH_ADV && !pc_busy; endsequence
  sequence dir_rd; DATA_RD && !INDIRECT; endsequence
  reset_vec_a: assert property ($fell(RESET) |-> PROG_ADDR == 13'h0000) else $error("no reset vector");
  pc_wrap_a: assert property (only_fetch |=> PROG_ADDR == (($past(PROG_ADDR) + 13'h1) & MSK)) else $error("pc step");
  int_vec_a: assert property (INT_TAKE |=> PROG_ADDR == 13'h0004) else $error("no int vector");
  jump_low_a: assert property ((JUMP || CALL) && !INT_TAKE && !RETURN |=> PROG_ADDR[10:0] == $past(JUMP_ADDR))
    else $error("jump target");
  endur_flag_a: assert property (PROG_ENDURANCE == (PROG_ADDR >= EDGE)) else $error("endurance flag");
  bank_pick_a: assert property (DATA_WR && !INDIRECT && DATA_ADDR == 7'h03 |=> BANK_SEL == $past(WR_DATA[6:5]))
    else $error("bank select");
  dir_addr_a: assert property (dir_rd |=> DATA_FULL_ADDR == {$past(BANK_SEL), $past(DATA_ADDR)}) else $error("address");
  unimp_zero_a: assert property (dir_rd ##0 DATA_ADDR == 7'h08 |=> RD_DATA == 8'h00 && PERIPH_SEL) else $error("unimp");
endmodule
bind bmd_memory_map bmd_memory_map_monitor #(.LARGE(LARGE)) u_bmd_memory_map_monitor (.*);

// ===== dv/bmd_memory_map_tb.sv
`timescale 1ns/1ps
module bmd_memory_map_tb;
  reg SYS_CLK = 1'h0;
  reg RESET = 1'h1;
  wire FETCH_ADV, JUMP, CALL, RETURN, INT_TAKE, DATA_RD, DATA_WR, INDIRECT, PROG_ENDURANCE, PERIPH_SEL;
  wire [10:0] JUMP_ADDR;
  wire [6:0] DATA_ADDR;
  wire [7:0] WR_DATA, RD_DATA;
  wire [12:0] PROG_ADDR;
  wire [8:0] DATA_FULL_ADDR;
  wire [1:0] BANK_SEL;
  integer num_errors = 0, checks_done = 0, cyc = 0, b;
  reg [7:0] dat [0:3];
  reg [7:0] val;
  bmd_memory_map #(.LARGE(1)) u_bmd_memory_map (.*);
  bmd_core_model u_bmd_core_model (.*);
  always #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  function [7:0] ram_exp(input [1:0] bk, input [7:0] d);
    ram_exp = (bk == 2'h3) ? 8'h00 : d;
  endfunction
  task chk(input [12:0] got, input [12:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task go(input [6:0] s, input [10:0] a, input [7:0] d, input i);
    u_bmd_core_model.go(s, a, d, i);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hD803));
    repeat (3) @(negedge SYS_CLK);
    RESET = 1'h0;
    chk(PROG_ADDR, 13'h0000);
    for (b = 0; b < 4; b = b + 1) begin
      dat[b] = $urandom;
      go(7'h01, 11'h003, {1'h0, b[1:0], 5'h18}, 1'h0);
      chk({11'h0, BANK_SEL}, {11'h0, b[1:0]});
      go(7'h01, 11'h020, dat[b], 1'h0);
      go(7'h02, 11'h020, 8'h00, 1'h0);
      chk({5'h0, RD_DATA}, {5'h0, ram_exp(b[1:0], dat[b])});
      chk({4'h0, DATA_FULL_ADDR}, {4'h0, b[1:0], 7'h20});
      $display("bank %0d done", b);
    end
    go(7'h01, 11'h070, 8'h5A, 1'h0);
    go(7'h01, 11'h003, 8'h18, 1'h0);
    go(7'h01, 11'h004, 8'hA0, 1'h0);
    go(7'h02, 11'h070, 8'h00, 1'h0);
    chk({5'h0, RD_DATA}, 13'h005A);
    go(7'h01, 11'h003, 8'h58, 1'h0);
    go(7'h02, 11'h004, 8'h00, 1'h0);
    chk({5'h0, RD_DATA}, 13'h00A0);
    go(7'h02, 11'h000, 8'h00, 1'h1);
    chk({5'h0, RD_DATA}, {5'h0, dat[1]});
    go(7'h01, 11'h008, 8'hFF, 1'h0);
    go(7'h02, 11'h008, 8'h00, 1'h0);
    chk({4'h0, PERIPH_SEL, RD_DATA}, 13'h0100);
    $display("data map done");
    go(7'h01, 11'h00A, 8'h08, 1'h0);
    go(7'h20, 11'h7FF, 8'h00, 1'h0);
    chk(PROG_ADDR, 13'h0FFF);
    chk({12'h0, PROG_ENDURANCE}, 13'h0001);
    go(7'h40, 11'h000, 8'h00, 1'h0);
    chk(PROG_ADDR, 13'h0000);
    go(7'h10, 11'h123, 8'h00, 1'h0);
    go(7'h04, 11'h000, 8'h00, 1'h0);
    chk(PROG_ADDR, 13'h0004);
    repeat ($urandom % 6) go(7'h40, 11'h000, 8'h00, 1'h0);
    go(7'h08, 11'h000, 8'h00, 1'h0);
    chk(PROG_ADDR, 13'h0924);
    go(7'h08, 11'h000, 8'h00, 1'h0);
    chk(PROG_ADDR, 13'h0001);
    go(7'h01, 11'h002, 8'h34, 1'h0);
    chk(PROG_ADDR, 13'h0834);
    chk({12'h0, PROG_ENDURANCE}, 13'h0000);
    go(7'h02, 11'h002, 8'h00, 1'h0);
    chk({5'h0, RD_DATA}, 13'h0034);
    go(7'h02, 11'h00A, 8'h00, 1'h0);
    chk({5'h0, RD_DATA}, 13'h0008);
    val = $urandom;
    go(7'h01, 11'h00B, val, 1'h0);
    go(7'h02, 11'h00B, 8'h00, 1'h0);
    chk({5'h0, RD_DATA}, {5'h0, val});
    $display("program flow done");
    RESET = 1'h1;
    @(negedge SYS_CLK);
    RESET = 1'h0;
    chk({BANK_SEL, PROG_ADDR[10:0]}, 13'h0000);
    repeat (2) @(negedge SYS_CLK);
    chk(PROG_ADDR, 13'h0000);
    $display("second reset done");
    test_done;
  end
endmodule
